// file: design/tx_dma_pkg.sv
// Purpose: Shared constants and types for the transmit DMA host request path
// Assumes: Single bus clock domain
// Notes: Register offsets are byte addresses
package tx_dma_pkg;
    localparam logic [15:0] RDT_OFFSET = 16'h2820;
    localparam logic [15:0] RDC_OFFSET = 16'h2828;
    localparam logic [15:0] TDC_OFFSET = 16'h3828;
    localparam logic [31:0] RDT_RESET = 32'h0000_0000;
    localparam logic [31:0] RDC_RESET = 32'h0000_0000;
    localparam logic [31:0] TDC_RESET = 32'h0000_0000;
    localparam int WTH_LSB = 16;
    localparam int WTH_W = 6;
    localparam int PTH_LSB = 0;
    localparam int PTH_W = 6;
    localparam logic [15:0] CSUM_ZERO = 16'h0000;
    localparam logic [15:0] CSUM_ONES = 16'hffff;
    localparam int QUEUE_DEPTH = 4;
    localparam int REQ_W = 40;
    localparam logic [7:0] WB_STATUS_BYTES = 8'h01;
    localparam logic [7:0] WB_DESC_BYTES = 8'h10;
    localparam logic [1:0] WIDTH_SETTLE = 2'h2;
    typedef enum logic [1:0] {
        WB_IDLE,
        WB_COLLECT,
        WB_ISSUE
    } wb_state_t;
endpackage : tx_dma_pkg

// file: design/req_if.sv
// Purpose: Request handshake between the DMA side and the host request queue
// Assumes: Same clock on both ends
// Notes: Valid/ready handshake
`timescale 1ns/1ps
interface req_if #(parameter int W = 40);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : req_if

// file: design/host_req_queue.sv
// Purpose: In-order queue of outstanding host bus requests
// Assumes: Single clock, clock enable freezes state
// Notes: Ready drops when full but ignores i_ce, so a request offered while i_ce is low is lost
`timescale 1ns/1ps
module host_req_queue
    import tx_dma_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH,
    parameter int W = REQ_W
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    req_if.dst in_req,
    req_if.src out_req,
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } q_state_t;
    q_state_t s_reg;
    q_state_t s_next;
    logic [W-1:0] mem [DEPTH];
    logic push;
    logic pop;
    assign in_req.ready = (s_reg.cnt != (AW+1)'(DEPTH));
    assign out_req.valid = (s_reg.cnt != '0);
    assign out_req.data = mem[s_reg.rd];
    assign push = in_req.valid && in_req.ready && i_ce;
    assign pop = out_req.valid && out_req.ready && i_ce;
    assign o_level = s_reg.cnt;
    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.wr = s_reg.wr + AW'(1);
        end
        if (pop) begin
            s_next.rd = s_reg.rd + AW'(1);
        end
        s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_reg <= '0;
        end else if (i_ce) begin
            s_reg <= s_next;
        end
    end
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[s_reg.wr] <= in_req.data;
        end
    end
endmodule : host_req_queue

// file: design/tx_dma_host_request_path.sv
// Purpose: Host side DMA path: request queue, descriptor write-back, checksum insert, bus width
// Assumes: One 40 MHz bus clock; bus reset drives i_rst_b
// Notes: Registers sit at fixed byte offsets on a simple register port
`timescale 1ns/1ps
module tx_dma_host_request_path
    import tx_dma_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH,
    parameter int W = REQ_W
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_req64_b,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    input wire logic i_dma_valid,
    input wire logic [W-1:0] i_dma_req,
    output logic o_dma_ready,
    output logic o_bus_valid,
    output logic [W-1:0] o_bus_req,
    input wire logic i_bus_ready,
    output logic [2:0] o_queue_level,
    input wire logic i_csum_valid,
    input wire logic i_csum_is_udp,
    input wire logic [15:0] i_csum_value,
    output logic o_csum_valid,
    output logic [15:0] o_csum_value,
    input wire logic i_desc_done,
    input wire logic i_tx_irq,
    input wire logic i_data_read_idle,
    output logic o_wb_valid,
    output logic [7:0] o_wb_count,
    output logic [7:0] o_wb_bytes,
    output logic o_wb_full_desc,
    input wire logic i_wb_ready,
    output logic o_bus_64
);
    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic [1:0] settle;
        logic width_taken;
        logic bus_64;
        logic [31:0] rdt;
        logic [31:0] rdc;
        logic [31:0] tdc;
        logic [31:0] rdata;
        logic csum_valid;
        logic [15:0] csum_value;
        wb_state_t wb_state;
        logic [7:0] pending;
        logic [7:0] wb_count;
        logic [7:0] wb_bytes;
        logic wb_full;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic [WTH_W-1:0] writeback_threshold;
    logic wb_fire;
    logic [7:0] pend_inc;
    logic [7:0] unit_bytes;
    logic udp_zero;
    logic wb_start;
    logic batch_reached;
    logic flush_early;
    logic [7:0] burst_bytes;

    req_if #(.W(W)) dma_req ();
    req_if #(.W(W)) bus_req ();
    assign dma_req.valid = i_dma_valid;
    assign dma_req.data = i_dma_req;
    assign o_dma_ready = dma_req.ready;
    assign o_bus_valid = bus_req.valid;
    assign o_bus_req = bus_req.data;
    assign bus_req.ready = i_bus_ready;
    host_req_queue #(.DEPTH(DEPTH), .W(W)) u_queue (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .in_req(dma_req.dst),
        .out_req(bus_req.src),
        .o_level(o_queue_level)
    );
    assign writeback_threshold = s_reg.tdc[WTH_LSB +: WTH_W];
    assign pend_inc = 8'(i_desc_done);
    assign unit_bytes = (writeback_threshold != '0) ? WB_DESC_BYTES : WB_STATUS_BYTES;
    assign wb_fire = (s_reg.wb_state == WB_ISSUE) && i_wb_ready;
    assign udp_zero = i_csum_is_udp && (i_csum_value == CSUM_ZERO);
    assign wb_start = (s_reg.pending != '0) || i_desc_done;
    assign batch_reached = (s_reg.pending >= 8'(writeback_threshold));
    assign flush_early = i_tx_irq || i_data_read_idle;
    assign burst_bytes = 8'(s_reg.pending * unit_bytes);

    always_comb begin
        s_next = s_reg;
        // Bus width pin: two synchroniser stages, capture once both hold the pin
        s_next.req_s1 = i_req64_b;
        s_next.req_s2 = s_reg.req_s1;
        if (!s_reg.width_taken) begin
            if (s_reg.settle == WIDTH_SETTLE) begin
                s_next.width_taken = 1'b1;
                s_next.bus_64 = ~s_reg.req_s2;
            end else begin
                s_next.settle = s_reg.settle + 2'h1;
            end
        end

        // Register port writes
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                RDT_OFFSET: begin
                    s_next.rdt = i_reg_wdata;
                end
                RDC_OFFSET: begin
                    s_next.rdc = i_reg_wdata;
                end
                TDC_OFFSET: begin
                    s_next.tdc = i_reg_wdata;
                end
                default: begin
                    s_next.rdt = s_reg.rdt;
                end
            endcase
        end

        // Register port reads, unmapped offsets read as zero
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                RDT_OFFSET: begin
                    s_next.rdata = s_reg.rdt;
                end
                RDC_OFFSET: begin
                    s_next.rdata = s_reg.rdc;
                end
                TDC_OFFSET: begin
                    s_next.rdata = s_reg.tdc;
                end
                default: begin
                    s_next.rdata = '0;
                end
            endcase
        end

        // Checksum substitution, only UDP maps an all-zero sum to all ones
        s_next.csum_valid = i_csum_valid;
        if (i_csum_valid) begin
            if (udp_zero) begin
                s_next.csum_value = CSUM_ONES;
            end else begin
                s_next.csum_value = i_csum_value;
            end
        end

        // Descriptor write-back
        s_next.pending = s_reg.pending + pend_inc;
        unique case (s_reg.wb_state)
            WB_IDLE: begin
                if (wb_start) begin
                    // Zero threshold skips batching
                    if (writeback_threshold == '0) begin
                        s_next.wb_state = WB_ISSUE;
                    end else begin
                        s_next.wb_state = WB_COLLECT;
                    end
                end
            end
            WB_COLLECT: begin
                if (batch_reached) begin
                    s_next.wb_state = WB_ISSUE;
                end else if (flush_early) begin
                    s_next.wb_state = WB_ISSUE;
                end
            end
            WB_ISSUE: begin
                if (s_reg.wb_count == '0) begin
                    // Latch one burst: whole descriptors when batching, status bytes otherwise
                    s_next.wb_count = s_reg.pending;
                    s_next.wb_full = (writeback_threshold != '0);
                    s_next.wb_bytes = burst_bytes;
                end else if (wb_fire) begin
                    s_next.pending = s_reg.pending - s_reg.wb_count + pend_inc;
                    s_next.wb_count = '0;
                    s_next.wb_bytes = '0;
                    s_next.wb_state = WB_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_reg <= '0;
            s_reg.rdt <= RDT_RESET;
            s_reg.rdc <= RDC_RESET;
            s_reg.tdc <= TDC_RESET;
            s_reg.wb_state <= WB_IDLE;
        end else if (i_ce) begin
            s_reg <= s_next;
        end
    end
    assign o_reg_rdata = s_reg.rdata;
    assign o_csum_valid = s_reg.csum_valid;
    assign o_csum_value = s_reg.csum_value;
    assign o_wb_valid = (s_reg.wb_state == WB_ISSUE) && (s_reg.wb_count != '0);
    assign o_wb_count = s_reg.wb_count;
    assign o_wb_bytes = s_reg.wb_bytes;
    assign o_wb_full_desc = s_reg.wb_full;
    assign o_bus_64 = s_reg.bus_64;
endmodule : tx_dma_host_request_path

// file: verif/bus_partner.sv
// Purpose: Host bridge model that takes requests off the bus side
// Assumes: Same clock as the block
// Notes: Stall keeps ready low to back up the queue
`timescale 1ns/1ps
module bus_partner (
    input wire logic i_stall,
    output logic o_bus_ready
);
    assign o_bus_ready = !i_stall;
endmodule : bus_partner

// file: verif/tx_dma_host_request_path_chk.sv
// Purpose: Port checks for the host request path
// Assumes: One clock, async active-low reset
// Notes: Threshold tracked from register writes
`timescale 1ns/1ps
module tx_dma_host_request_path_chk
    import tx_dma_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_reg_wr,
    input wire logic [15:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic o_dma_ready,
    input wire logic o_bus_valid,
    input wire logic [2:0] o_queue_level,
    input wire logic i_csum_valid,
    input wire logic i_csum_is_udp,
    input wire logic [15:0] i_csum_value,
    input wire logic o_csum_valid,
    input wire logic [15:0] o_csum_value,
    input wire logic i_desc_done,
    input wire logic o_wb_valid,
    input wire logic [7:0] o_wb_count,
    input wire logic [7:0] o_wb_bytes,
    input wire logic o_wb_full_desc
);
    logic thr_zero_reg;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            thr_zero_reg <= 1'b1;
        end else if (i_ce && i_reg_wr && i_reg_addr == TDC_OFFSET) begin
            thr_zero_reg <= i_reg_wdata[WTH_LSB+:WTH_W] == '0;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence done_idle_s;
        i_ce && i_desc_done && thr_zero_reg && !o_wb_valid;
    endsequence
    sequence wb_soon_s;
        ##[1:3] o_wb_valid;
    endsequence
    udp_zero_fix_a: assert property (i_ce && i_csum_valid && i_csum_is_udp
        && i_csum_value == CSUM_ZERO |=> o_csum_valid && o_csum_value == CSUM_ONES)
        else $error("udp zero not replaced");
    tcp_unchanged_a: assert property (i_ce && i_csum_valid && !i_csum_is_udp
        |=> o_csum_valid && o_csum_value == $past(i_csum_value)) else $error("tcp sum altered");
    nonzero_pass_a: assert property (i_ce && i_csum_valid && i_csum_value != CSUM_ZERO
        |=> o_csum_value == $past(i_csum_value)) else $error("nonzero sum altered");
    queue_bound_a: assert property (o_queue_level <= 3'h4) else $error("queue over four");
    full_hold_a: assert property (o_queue_level == 3'h4 |-> !o_dma_ready)
        else $error("ready while full");
    bus_offer_a: assert property (o_queue_level != 3'h0 |-> o_bus_valid)
        else $error("held request not offered");
    wb_length_a: assert property (o_wb_valid |-> o_wb_bytes ==
        (o_wb_full_desc ? {o_wb_count[3:0], 4'h0} : o_wb_count)) else $error("bad burst size");
    wb_kind_a: assert property (o_wb_valid |-> o_wb_full_desc == !thr_zero_reg)
        else $error("wrong write-back unit");
    wb_prompt_a: assert property (done_idle_s |-> wb_soon_s)
        else $error("write-back late");
endmodule : tx_dma_host_request_path_chk
bind tx_dma_host_request_path tx_dma_host_request_path_chk chk_inst (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_reg_wr(i_reg_wr),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .o_dma_ready(o_dma_ready),
    .o_bus_valid(o_bus_valid),
    .o_queue_level(o_queue_level),
    .i_csum_valid(i_csum_valid),
    .i_csum_is_udp(i_csum_is_udp),
    .i_csum_value(i_csum_value),
    .o_csum_valid(o_csum_valid),
    .o_csum_value(o_csum_value),
    .i_desc_done(i_desc_done),
    .o_wb_valid(o_wb_valid),
    .o_wb_count(o_wb_count),
    .o_wb_bytes(o_wb_bytes),
    .o_wb_full_desc(o_wb_full_desc)
);

// file: verif/tx_dma_host_request_path_tb.sv
// Purpose: Self-checking bench for the host request path
// Assumes: 40 MHz clock, bridge model drives bus ready
// Notes: Checksum cases run from a table
`timescale 1ns/1ps
module tx_dma_host_request_path_tb;
    import tx_dma_pkg::*;
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_ce = 1'b1, i_req64_b = 1'b0, stall = 1'b0;
    logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_dma_valid = 1'b0, i_bus_ready, i_wb_ready = 1'b0;
    logic i_csum_valid = 1'b0, i_csum_is_udp = 1'b0, i_desc_done = 1'b0, i_tx_irq = 1'b0;
    logic i_data_read_idle = 1'b0;
    logic [15:0] i_reg_addr = '0, i_csum_value = '0, o_csum_value;
    logic [31:0] i_reg_wdata = '0, o_reg_rdata;
    logic [39:0] i_dma_req = '0, o_bus_req;
    logic [7:0] o_wb_count, o_wb_bytes;
    logic [2:0] o_queue_level;
    logic o_dma_ready, o_bus_valid, o_csum_valid, o_wb_valid, o_wb_full_desc, o_bus_64;
    logic [32:0] cs_rows [4] = '{{1'b1, 16'h0000, 16'hffff}, {1'b0, 16'h0000, 16'h0000},
        {1'b1, 16'h1234, 16'h1234}, {1'b0, 16'hffff, 16'hffff}};
    int miscompares = 0, check_count = 0, cyc = 0;
    tx_dma_host_request_path tx_dma_host_request_path_inst (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_req64_b(i_req64_b),
        .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata),
        .i_dma_valid(i_dma_valid),
        .i_dma_req(i_dma_req),
        .o_dma_ready(o_dma_ready),
        .o_bus_valid(o_bus_valid),
        .o_bus_req(o_bus_req),
        .i_bus_ready(i_bus_ready),
        .o_queue_level(o_queue_level),
        .i_csum_valid(i_csum_valid),
        .i_csum_is_udp(i_csum_is_udp),
        .i_csum_value(i_csum_value),
        .o_csum_valid(o_csum_valid),
        .o_csum_value(o_csum_value),
        .i_desc_done(i_desc_done),
        .i_tx_irq(i_tx_irq),
        .i_data_read_idle(i_data_read_idle),
        .o_wb_valid(o_wb_valid),
        .o_wb_count(o_wb_count),
        .o_wb_bytes(o_wb_bytes),
        .o_wb_full_desc(o_wb_full_desc),
        .i_wb_ready(i_wb_ready),
        .o_bus_64(o_bus_64)
    );
    bus_partner bus_partner_inst (.i_stall(stall), .o_bus_ready(i_bus_ready));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic reg_cycle(input logic wr, input logic [15:0] a, input logic [31:0] d);
        i_reg_wr <= wr;
        i_reg_rd <= !wr;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b0;
        @(posedge i_clk);
        if (!wr) check(o_reg_rdata, d);
    endtask : reg_cycle
    task automatic take_wb(input logic [7:0] n, input logic full);
        for (int i = 0; i < 20 && o_wb_valid !== 1'b1; i++) @(posedge i_clk);
        check({o_wb_full_desc, o_wb_count, o_wb_bytes}, {full, n, full ? {n[3:0], 4'h0} : n});
        i_wb_ready <= 1'b1;
        @(posedge i_clk);
        i_wb_ready <= 1'b0;
    endtask : take_wb
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        for (int b = 1; b >= 0; b--) begin
            i_rst_b <= 1'b0;
            i_req64_b <= b[0];
            repeat (20) @(posedge i_clk);
            i_rst_b <= 1'b1;
            repeat (5) @(posedge i_clk);
            check(32'(o_bus_64), 32'(!b[0]));
        end
        reg_cycle(1'b0, RDT_OFFSET, RDT_RESET);
        reg_cycle(1'b0, RDC_OFFSET, RDC_RESET);
        reg_cycle(1'b0, TDC_OFFSET, TDC_RESET);
        reg_cycle(1'b1, RDT_OFFSET, 32'h0000_00a5);
        reg_cycle(1'b0, RDT_OFFSET, 32'h0000_00a5);
        reg_cycle(1'b0, 16'h0100, 32'h0000_0000);
        foreach (cs_rows[r]) begin
            {i_csum_is_udp, i_csum_value} <= cs_rows[r][32:16];
            i_csum_valid <= 1'b1;
            @(posedge i_clk);
            i_csum_valid <= 1'b0;
            @(posedge i_clk);
            check({o_csum_valid, o_csum_value}, {1'b1, cs_rows[r][15:0]});
        end
        i_ce <= 1'b0;
        {i_csum_is_udp, i_csum_value} <= {1'b1, CSUM_ZERO};
        i_csum_valid <= 1'b1;
        @(posedge i_clk);
        i_csum_valid <= 1'b0;
        @(posedge i_clk);
        check({o_csum_valid, o_csum_value}, {1'b0, 16'hffff});
        i_ce <= 1'b1;
        stall <= 1'b1;
        i_dma_valid <= 1'b1;
        for (int k = 1; k <= 5; k++) begin
            i_dma_req <= 40'(k);
            @(posedge i_clk);
        end
        check({o_queue_level, o_dma_ready}, {3'h4, 1'b0});
        stall <= 1'b0;
        for (int k = 1; k <= 5; k++) begin
            @(posedge i_clk);
            if (k == 2) i_dma_valid <= 1'b0;
            check({o_bus_valid, o_bus_req[30:0]}, 32'(k) | 32'h8000_0000);
        end
        i_desc_done <= 1'b1;
        @(posedge i_clk);
        i_desc_done <= 1'b0;
        take_wb(8'h01, 1'b0);
        reg_cycle(1'b1, TDC_OFFSET, 32'h0002_0000);
        i_desc_done <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_desc_done <= 1'b0;
        take_wb(8'h02, 1'b1);
        reg_cycle(1'b1, TDC_OFFSET, 32'h0003_0000);
        for (int t = 0; t < 2; t++) begin
            i_desc_done <= 1'b1;
            @(posedge i_clk);
            i_desc_done <= 1'b0;
            repeat (5) @(posedge i_clk);
            check(32'(o_wb_valid), 32'h0);
            i_tx_irq <= (t == 0);
            i_data_read_idle <= (t == 1);
            take_wb(8'h01, 1'b1);
            i_tx_irq <= 1'b0;
            i_data_read_idle <= 1'b0;
        end
        end_sim();
    end
endmodule : tx_dma_host_request_path_tb
